/* File: eag_pkg.sv */
// Shared constants and types of the effective address generator
package eag_pkg;

  typedef enum logic [2:0] {
    M_DREG  = 3'b000,
    M_AREG  = 3'b001,
    M_IND   = 3'b010,
    M_POST  = 3'b011,
    M_PRE   = 3'b100,
    M_DISP  = 3'b101,
    M_INDEX = 3'b110,
    M_SPEC  = 3'b111
  } eag_mode_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } eag_size_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_BASE   = 3'b001,
    S_EXT    = 3'b010,
    S_IDX    = 3'b011,
    S_FINISH = 3'b100
  } eag_state_t;

  localparam int EA_MODE_HI   = 5;
  localparam int EA_MODE_LO   = 3;
  localparam int EA_REG_HI    = 2;
  localparam int EA_REG_LO    = 0;
  localparam logic [2:0] STACK_POINTER_REG = 3'h7;
  localparam logic [31:0] STEP_1 = 32'h1;
  localparam logic [31:0] STEP_2 = 32'h2;
  localparam logic [31:0] STEP_4 = 32'h4;
  localparam int IDX_AREG_BIT = 15;
  localparam int IDX_REG_HI   = 14;
  localparam int IDX_REG_LO   = 12;
  localparam int IDX_LONG_BIT = 11;
  localparam int DISP8_SIGN   = 7;
  localparam logic [31:0] ADDR_RST = 32'h0;
  localparam logic [15:0] WORD_RST = 16'h0;
  localparam logic [3:0]  IDX_RST  = 4'h0;

endpackage : eag_pkg

/* File: eag_ext_if.sv */
// Carrier between the address sequencer and the extension word unit
`timescale 1ns/100ps
interface eag_ext_if;
  logic        start;
  logic        done;
  logic [31:0] disp16_sx;
  logic [31:0] disp8_sx;
  logic [3:0]  idx_sel;
  logic        idx_long;

  modport ctl   (output start, input done, disp16_sx, disp8_sx, idx_sel,
                 idx_long);
  modport fetch (input start, output done, disp16_sx, disp8_sx, idx_sel,
                 idx_long);
endinterface : eag_ext_if

/* File: eag_ext_unit.sv */
// Extension word fetch and field decode
`timescale 1ns/100ps
module eag_ext_unit (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  output logic             ext_req_r,
  input  wire logic        ext_valid,
  input  wire logic [15:0] ext_word,
  eag_ext_if.fetch         xf
);

  logic [15:0] word_r;
  logic        done_r;
  logic        take;

  assign take = ext_req_r && ext_valid;

  // Word right after the operation word belongs to the same instruction
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ext_req_r <= 1'b0;
      done_r    <= 1'b0;
      word_r    <= eag_pkg::WORD_RST;
    end
    else
    begin
      done_r <= take;
      if (take)
      begin
        ext_req_r <= 1'b0;
        word_r    <= ext_word;
      end
      else if (xf.start)
        ext_req_r <= 1'b1;
    end
  end

  assign xf.done      = done_r;
  assign xf.disp16_sx = {{16{word_r[15]}}, word_r};
  assign xf.disp8_sx  = {{24{word_r[eag_pkg::DISP8_SIGN]}},
                         word_r[eag_pkg::DISP8_SIGN:0]};
  assign xf.idx_sel   = {word_r[eag_pkg::IDX_AREG_BIT],
                         word_r[eag_pkg::IDX_REG_HI:eag_pkg::IDX_REG_LO]};
  assign xf.idx_long  = word_r[eag_pkg::IDX_LONG_BIT];

endmodule : eag_ext_unit

/* File: eag_addr_gen.sv */
// Effective address decode and operand address sequencer
`timescale 1ns/100ps
// Operation
// - The six-bit address field splits into a 3-bit mode and a 3-bit register number.
// - The mode picks the addressing mode and the register number picks its register.
// - Extra operand information comes from the words right after the operation word, as part of the instruction.
// - Register direct modes place the operand in one of 16 general registers, not memory.
// - Data register direct uses the data register named by the register number.
// - Address register direct uses the address register named by the register number.
// - Indirect mode uses the address register as the address, a data reference unless it is a jump.
// - Postincrement uses the register then adds one, two or four for byte, word or long, as data.
// - A byte postincrement of the stack pointer adds two to keep it word aligned.
// - Predecrement subtracts one, two or four first and then uses the register, as data.
// - A byte predecrement of the stack pointer subtracts two to keep it word aligned.
// - Displacement mode takes one extension word and adds its sign-extended 16 bits to the register.
// - Index mode takes one extension word and adds its sign-extended low byte and an index register.
// - Mode codes 000 to 110 map to the seven register modes; 111 selects the special modes.
// - The stack pointer meant above is address register seven.
module eag_addr_gen (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [5:0]  ea_field,
  input  wire logic [1:0]  op_size,
  input  wire logic        is_jump,
  output logic             busy_r,
  output logic             ext_req_r,
  input  wire logic        ext_valid,
  input  wire logic [15:0] ext_word,
  output logic [3:0]       rf_rd_idx_r,
  input  wire logic [31:0] rf_rd_data,
  output logic             done_r,
  output logic [31:0]      ea_addr_r,
  output logic             is_mem_r,
  output logic             data_ref_r,
  output logic             direct_r,
  output logic [3:0]       direct_idx_r,
  output logic             special_r,
  output logic             wb_en_r,
  output logic [3:0]       wb_idx_r,
  output logic [31:0]      wb_data_r
);

  eag_pkg::eag_state_t st_r;
  eag_pkg::eag_state_t st_nxt;
  eag_pkg::eag_mode_t  mode_r;
  logic [2:0]          reg_r;
  logic [1:0]          size_r;
  logic                jump_r;
  logic [31:0]         base_r;
  logic [31:0]         idx_r;
  logic [31:0]         step;
  logic [31:0]         ea_calc;
  logic [31:0]         wb_calc;
  logic [31:0]         idx_val;
  logic                take;
  logic                is_direct;
  logic                is_special;
  logic                needs_ext;
  logic                is_update;
  logic                on_sp;

  eag_ext_if xf ();

  eag_ext_unit u_ext (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ext_req_r (ext_req_r),
    .ext_valid (ext_valid),
    .ext_word  (ext_word),
    .xf        (xf)
  );

  assign take       = (st_r == eag_pkg::S_IDLE) && start;
  assign is_direct  = (mode_r == eag_pkg::M_DREG) ||
                      (mode_r == eag_pkg::M_AREG);
  assign is_special = (mode_r == eag_pkg::M_SPEC);
  assign needs_ext  = (mode_r == eag_pkg::M_DISP) ||
                      (mode_r == eag_pkg::M_INDEX);
  assign is_update  = (mode_r == eag_pkg::M_POST) ||
                      (mode_r == eag_pkg::M_PRE);
  assign on_sp      = (reg_r == eag_pkg::STACK_POINTER_REG);
  assign xf.start   = (st_r == eag_pkg::S_BASE) && needs_ext;

  // Byte steps on the stack pointer go by two so it never turns odd
  assign step = (size_r == eag_pkg::SZ_BYTE) ?
                (on_sp ? eag_pkg::STEP_2 : eag_pkg::STEP_1) :
                (size_r == eag_pkg::SZ_WORD) ? eag_pkg::STEP_2 :
                eag_pkg::STEP_4;

  // Plain 32-bit sums wrap on overflow
  assign ea_calc =
    (mode_r == eag_pkg::M_PRE)   ? base_r - step :
    (mode_r == eag_pkg::M_DISP)  ? base_r + xf.disp16_sx :
    (mode_r == eag_pkg::M_INDEX) ? base_r + xf.disp8_sx + idx_r :
    base_r;
  assign wb_calc = (mode_r == eag_pkg::M_POST) ? base_r + step :
                   base_r - step;
  assign idx_val = xf.idx_long ? rf_rd_data :
                   {{16{rf_rd_data[15]}}, rf_rd_data[15:0]};

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      eag_pkg::S_IDLE:
        if (start)
          st_nxt = (ea_field[5:4] == 2'b00 || ea_field[5:3] == 3'b111) ?
                   eag_pkg::S_FINISH : eag_pkg::S_BASE;
      eag_pkg::S_BASE:
        st_nxt = needs_ext ? eag_pkg::S_EXT : eag_pkg::S_FINISH;
      eag_pkg::S_EXT:
        if (xf.done)
          st_nxt = (mode_r == eag_pkg::M_INDEX) ? eag_pkg::S_IDX :
                   eag_pkg::S_FINISH;
      eag_pkg::S_IDX:
        st_nxt = eag_pkg::S_FINISH;
      eag_pkg::S_FINISH:
        st_nxt = eag_pkg::S_IDLE;
      default:
        st_nxt = eag_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r   <= eag_pkg::S_IDLE;
      mode_r <= eag_pkg::M_DREG;
      reg_r  <= 3'h0;
      size_r <= eag_pkg::SZ_BYTE;
      jump_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      busy_r <= (st_nxt != eag_pkg::S_IDLE);
      if (take)
      begin
        mode_r <= eag_pkg::eag_mode_t'(
                  ea_field[eag_pkg::EA_MODE_HI:eag_pkg::EA_MODE_LO]);
        reg_r  <= ea_field[eag_pkg::EA_REG_HI:eag_pkg::EA_REG_LO];
        size_r <= op_size;
        jump_r <= is_jump;
      end
    end
  end

  // Register file reads are combinational on the index we hold
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rf_rd_idx_r <= eag_pkg::IDX_RST;
      base_r      <= eag_pkg::ADDR_RST;
      idx_r       <= eag_pkg::ADDR_RST;
    end
    else
    begin
      if (take)
        rf_rd_idx_r <= {1'b1, ea_field[2:0]};
      else if (st_r == eag_pkg::S_EXT && xf.done)
        rf_rd_idx_r <= xf.idx_sel;
      if (st_r == eag_pkg::S_BASE)
        base_r <= rf_rd_data;
      if (st_r == eag_pkg::S_IDX)
        idx_r <= idx_val;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done_r       <= 1'b0;
      ea_addr_r    <= eag_pkg::ADDR_RST;
      is_mem_r     <= 1'b0;
      data_ref_r   <= 1'b0;
      direct_r     <= 1'b0;
      direct_idx_r <= eag_pkg::IDX_RST;
      special_r    <= 1'b0;
      wb_en_r      <= 1'b0;
      wb_idx_r     <= eag_pkg::IDX_RST;
      wb_data_r    <= eag_pkg::ADDR_RST;
    end
    else
    begin
      done_r  <= (st_r == eag_pkg::S_FINISH);
      wb_en_r <= (st_r == eag_pkg::S_FINISH) && is_update;
      if (st_r == eag_pkg::S_FINISH)
      begin
        ea_addr_r    <= ea_calc;
        is_mem_r     <= !is_direct && !is_special;
        direct_r     <= is_direct;
        direct_idx_r <= {(mode_r == eag_pkg::M_AREG), reg_r};
        special_r    <= is_special;
        // Update modes are always data; other memory modes yield to jumps
        data_ref_r   <= !is_direct && !is_special &&
                        (is_update || !jump_r);
        wb_idx_r     <= {1'b1, reg_r};
        wb_data_r    <= wb_calc;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_take;
    st_r == eag_pkg::S_IDLE && start;
  endsequence

  sequence s_ext_taken;
    ext_req_r && ext_valid;
  endsequence

  a_field_split:
    assert property (s_take |=> mode_r == $past(ea_field[5:3]) &&
                     reg_r == $past(ea_field[2:0]))
    else $error("mode or register field misdecoded");

  a_dreg_direct:
    assert property (s_take ##0 ea_field[5:3] == 3'b000 |=> ##1
                     done_r && direct_r && !direct_idx_r[3])
    else $error("data register direct not reported");

  a_areg_direct:
    assert property (s_take ##0 ea_field[5:3] == 3'b001 |=> ##1
                     done_r && direct_r && direct_idx_r[3])
    else $error("address register direct not reported");

  a_direct_nomem:
    assert property (done_r && direct_r |-> !is_mem_r && !wb_en_r)
    else $error("register direct treated as memory");

  a_ext_fetch_req:
    assert property (s_take ##0 ea_field[5:3] == 3'b101 |=> ##1 ext_req_r)
    else $error("extension word not requested");

  a_indir_ref:
    assert property (done_r && mode_r == eag_pkg::M_IND |->
                     ea_addr_r == base_r && data_ref_r == !jump_r)
    else $error("indirect address or class wrong");

  a_post_step:
    assert property (done_r && mode_r == eag_pkg::M_POST |->
                     wb_en_r && ea_addr_r == base_r && data_ref_r &&
                     wb_data_r == base_r + step)
    else $error("postincrement wrong");

  a_post_sp_byte:
    assert property (done_r && mode_r == eag_pkg::M_POST && reg_r == 3'h7
                     && size_r == eag_pkg::SZ_BYTE |->
                     wb_data_r - ea_addr_r == 32'h2)
    else $error("stack pointer byte postincrement not two");

  a_pre_step:
    assert property (done_r && mode_r == eag_pkg::M_PRE |->
                     wb_en_r && wb_data_r == ea_addr_r && data_ref_r)
    else $error("predecrement wrong");

  a_pre_sp_byte:
    assert property (done_r && mode_r == eag_pkg::M_PRE && reg_r == 3'h7
                     && size_r == eag_pkg::SZ_BYTE |->
                     base_r - ea_addr_r == 32'h2)
    else $error("stack pointer byte predecrement not two");

  a_disp_sum:
    assert property (done_r && mode_r == eag_pkg::M_DISP |->
                     ea_addr_r == base_r + xf.disp16_sx &&
                     data_ref_r == !jump_r)
    else $error("displacement address wrong");

  a_index_seq:
    assert property (s_ext_taken ##0 mode_r == eag_pkg::M_INDEX |=> ##1
                     rf_rd_idx_r == xf.idx_sel ##2 done_r &&
                     ea_addr_r == base_r + xf.disp8_sx + idx_r)
    else $error("index address sequence wrong");

  a_special_flag:
    assert property (s_take ##0 ea_field[5:3] == 3'b111 |=> ##1
                     done_r && special_r && !is_mem_r && !direct_r &&
                     !data_ref_r)
    else $error("special mode not passed on");

  a_base_select:
    assert property (s_take ##0 (ea_field[5:4] != 2'b00 &&
                     ea_field[5:3] != 3'b111) |=>
                     rf_rd_idx_r == {1'b1, reg_r} && busy_r)
    else $error("base register not selected");

  a_ext_single:
    assert property (s_ext_taken |=> !ext_req_r)
    else $error("extension request left open");

  // Plain registers step by one on bytes; only the stack pointer differs
  a_byte_plain:
    assert property (done_r && wb_en_r && size_r == eag_pkg::SZ_BYTE &&
                     reg_r != eag_pkg::STACK_POINTER_REG |->
                     (mode_r == eag_pkg::M_POST ? wb_data_r - ea_addr_r :
                      base_r - ea_addr_r) == 32'h1)
    else $error("byte step on a plain register not one");

  a_direct_class:
    assert property (done_r && direct_r |-> !data_ref_r && !special_r)
    else $error("register direct given a memory class");

endmodule : eag_addr_gen

/* File: test_eag_addr_gen.sv */
// Self-checking bench for the effective address generator
`timescale 1ns/100ps
module test_eag_addr_gen;
  logic        clk;
  logic        sys_rst;
  logic        start;
  logic [5:0]  ea_field;
  logic [1:0]  op_size;
  logic        is_jump;
  logic        busy_r, ext_req_r, ext_valid, done_r;
  logic        is_mem_r, data_ref_r, direct_r, special_r, wb_en_r;
  logic [15:0] ext_word;
  logic [3:0]  rf_rd_idx_r, direct_idx_r, wb_idx_r;
  logic [31:0] rf_rd_data, ea_addr_r, wb_data_r;
  logic [31:0] rf [16];
  logic        c_wb;
  int          took;
  int          err_total;
  int          checks;

  // Register file answers in the same cycle as the read index
  assign rf_rd_data = rf[rf_rd_idx_r];

  eag_addr_gen DUT (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .start        (start),
    .ea_field     (ea_field),
    .op_size      (op_size),
    .is_jump      (is_jump),
    .busy_r       (busy_r),
    .ext_req_r    (ext_req_r),
    .ext_valid    (ext_valid),
    .ext_word     (ext_word),
    .rf_rd_idx_r  (rf_rd_idx_r),
    .rf_rd_data   (rf_rd_data),
    .done_r       (done_r),
    .ea_addr_r    (ea_addr_r),
    .is_mem_r     (is_mem_r),
    .data_ref_r   (data_ref_r),
    .direct_r     (direct_r),
    .direct_idx_r (direct_idx_r),
    .special_r    (special_r),
    .wb_en_r      (wb_en_r),
    .wb_idx_r     (wb_idx_r),
    .wb_data_r    (wb_data_r)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic test_done();
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One request, called at a falling edge; the word is offered after
  // stall cycles of an open request, and is scrambled while not valid
  task automatic run(input logic [5:0] f, input logic [1:0] sz,
                     input logic j, input logic [15:0] w, input int stall);
    int n;
    n = 0;
    took = 0;
    start = 1'b1;
    ea_field = f;
    op_size = sz;
    is_jump = j;
    @(negedge clk);
    start = 1'b0;
    while (done_r !== 1'b1 && n < 40)
    begin
      if (ext_valid === 1'b1)
        took++;
      ext_valid = 1'b0;
      ext_word = ~w;
      if (ext_req_r === 1'b1 && stall > 0)
        stall--;
      else if (ext_req_r === 1'b1)
      begin
        ext_valid = 1'b1;
        ext_word = w;
      end
      @(negedge clk);
      n++;
    end
    ext_valid = 1'b0;
    c_wb = wb_en_r;
    chk(done_r, 1'b1, "no completion");
  endtask : run

  task automatic t_direct();
    for (int m = 0; m < 2; m++)
      for (int r = 0; r < 8; r++)
      begin
        run({m[2:0], r[2:0]}, 2'h2, 1'b0, 16'h1234, 0);
        chk(took, 0, "direct fetched words");
        chk(direct_r, 1'b1, "direct flag");
        chk(is_mem_r, 1'b0, "direct in memory");
        chk(direct_idx_r, {m[0], r[2:0]}, "direct reg");
      end
  endtask : t_direct

  // Indirect, post and pre on a plain register and the stack pointer
  task automatic t_memory();
    logic [31:0] base;
    logic [31:0] step;
    logic [31:0] nxt;
    logic [2:0]  r;
    rf[10] = 32'hffff_ffff;
    rf[15] = 32'h0000_0001;
    for (int m = 2; m < 5; m++)
      for (int k = 0; k < 2; k++)
        for (int s = 0; s < 3; s++)
        begin
          r = (k == 1) ? 3'h7 : 3'h2;
          base = rf[{1'b1, r}];
          step = (s == 2) ? 32'h4 : (s == 1) ? 32'h2 : 32'h1;
          if (s == 0 && r == 3'h7)
            step = 32'h2;
          nxt = (m == 3) ? base + step : base - step;
          run({m[2:0], r}, s[1:0], s[0], 16'h0, 0);
          chk(is_mem_r, 1'b1, "memory flag");
          chk(ea_addr_r, (m == 4) ? nxt : base, "address");
          chk(data_ref_r, (m != 2) || !s[0], "data class");
          chk(c_wb, m != 2, "writeback pulse");
          if (m != 2)
          begin
            chk(wb_data_r, nxt, "new pointer");
            chk(wb_idx_r, {1'b1, r}, "writeback reg");
          end
        end
  endtask : t_memory

  task automatic t_disp();
    logic [15:0] w;
    rf[13] = 32'h0000_4000;
    for (int k = 0; k < 2; k++)
    begin
      w = (k == 0) ? 16'h8000 : 16'h7ffe;
      run(6'o55, 2'h1, k[0], w, 2 - 2 * k);
      chk(took, 1, "one extension word");
      chk(ea_addr_r, 32'h4000 + {{16{w[15]}}, w}, "disp sum");
      chk(data_ref_r, !k[0], "disp class");
    end
  endtask : t_disp

  task automatic t_index();
    logic [15:0] w;
    logic [31:0] iv;
    rf[12] = 32'h1000_0000;
    rf[2] = 32'h1234_8000;
    for (int k = 0; k < 2; k++)
    begin
      w = (k == 0) ? 16'h9880 : 16'h2017;
      iv = rf[w[15:12]];
      if (!w[11])
        iv = {{16{iv[15]}}, iv[15:0]};
      run(6'o64, 2'h0, k[0], w, 1 - k);
      chk(took, 1, "one index word");
      chk(ea_addr_r, 32'h1000_0000 + {{24{w[7]}}, w[7:0]} + iv,
          "index sum");
      chk(data_ref_r, !k[0], "index class");
    end
  endtask : t_index

  task automatic t_special();
    run(6'o74, 2'h1, 1'b0, 16'h0, 0);
    chk(special_r, 1'b1, "special flag");
    chk(is_mem_r, 1'b0, "special memory");
    chk(direct_r, 1'b0, "special direct");
  endtask : t_special

  initial
  begin
    err_total = 0;
    checks = 0;
    sys_rst = 1'b1;
    start = 1'b0;
    ea_field = 6'h0;
    op_size = 2'h0;
    is_jump = 1'b0;
    ext_valid = 1'b0;
    ext_word = 16'h0;
    for (int i = 0; i < 16; i++)
      rf[i] = {8'(i), 24'h00a5c3};
    repeat (12) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk(busy_r, 1'b0, "busy after reset");
    t_direct();
    t_memory();
    t_disp();
    t_index();
    t_special();
    test_done();
  end

  // Expected run is well under two hundred cycles
  initial
  begin
    #(4000 * 25);
    err_total++;
    test_done();
  end
endmodule : test_eag_addr_gen
